/* File: rsmr_host.sv */
// host model that issues single-cycle register reads and writes
module rsmr_host (
    input  wire logic       mclk,
    input  wire logic [7:0] regRdata,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle from time zero
    initial begin
        regAddr  = 8'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
        regWdata = 8'h00;
    end
    // write strobe for one cycle; status places are never written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
        regWdata = ~d;    // released data stops showing the old value
    endtask : wr
    // read strobe for one cycle, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge mclk);
        regRead = 1'b0;
        d       = regRdata;
    endtask : rd
endmodule : rsmr_host

/* File: rsmr_pkg.sv */
// package with offsets, field layouts and reset values of the regulator bank
package rsmr_pkg;
    // register offsets
    localparam logic [7:0] OFS_BUCK_FOUR_STATUS   = 8'h08;
    localparam logic [7:0] OFS_LINEAR_ONE_STATUS  = 8'h09;
    localparam logic [7:0] OFS_LINEAR_TWO_STATUS  = 8'h0A;
    localparam logic [7:0] OFS_BUCK_ONE_ACTIVE    = 8'h10;
    localparam logic [7:0] OFS_BUCK_ONE_LOW_POWER = 8'h11;
    localparam logic [7:0] OFS_BUCK_ONE_HIBERNATE = 8'h12;
    // field positions
    localparam int BIT_FAULT        = 7;
    localparam int BIT_RETRY_OC     = 6;
    localparam int BIT_NEG_CURRENT_LIMIT_STATUS     = 5;
    localparam int BIT_ZERO_CROSS   = 4;
    localparam int BIT_RESERVED_B   = 3;
    localparam int BIT_CURRENT_LIM  = 3;
    localparam int BIT_SOFT_DONE    = 2;
    localparam int BIT_POWER_GOOD   = 1;
    localparam int BIT_ENABLED      = 0;
    // reset values of the mode and status registers (3.3 V code 110111)
    localparam logic [5:0] RST_VOLT_CODE   = 6'h37;
    localparam logic [7:0] RST_ACTIVE_SET  = 8'hF7;
    localparam logic [7:0] RST_LOWPWR_SET  = 8'hB7;
    localparam logic [7:0] RST_HIBERN_SET  = 8'h37;
    localparam logic [7:0] RST_STATUS      = 8'h00;
    // shutdown wait before restart of sequence
    localparam int RESTART_MS       = 100;
    localparam int CLK_HZ           = 40000000;
    localparam int RESTART_CYCLES   = CLK_HZ / 1000 * RESTART_MS;
    // operating modes
    typedef enum logic [2:0] {
        RSMR_ACTIVE    = 3'b001,
        RSMR_LOW_POWER = 3'b010,
        RSMR_HIBERNATE = 3'b100
    } rsmr_mode_t;
    // per-mode setting layout
    typedef struct packed {
        logic       enable;
        logic       forcedPwm;
        logic [5:0] outputVoltageCode;
    } rsmr_setting_t;
    // analog indications of one channel
    typedef struct packed {
        logic softStartDone;
        logic powerGood;
        logic enabledStatus;
        logic currentLimit;
    } rsmr_chan_t;
endpackage : rsmr_pkg

/* File: rsmr_regs.sv */
// register bank for regulator status and buck one mode settings
module rsmr_regs
    import rsmr_pkg::*;
#(
    parameter int RESTART_WAIT = RESTART_CYCLES  // shutdown wait in cycles
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          clkEn,
    input  wire logic [7:0]    regAddr,          // register offset
    input  wire logic          regWrite,         // one-cycle write strobe
    input  wire logic          regRead,          // one-cycle read strobe
    input  wire logic [7:0]    regWdata,
    output logic      [7:0]    regRdata,         // read data, registered
    input  wire logic [2:0]    opMode,           // one-hot operating mode
    input  wire logic          hsOcEndCount,     // overcurrent counter end
    input  wire logic          negLimitHit,
    input  wire logic          zeroCrossTrip,
    input  wire rsmr_chan_t    buckFourIn,
    input  wire rsmr_chan_t    linearOneIn,
    input  wire rsmr_chan_t    linearTwoIn,
    input  wire logic [2:0]    fault_mask,       // buck4, ldo1, ldo2
    input  wire logic          retry_protection_select,
    output logic               interrupt_out_n,
    output logic               buckOneEnable,
    output logic               buckOneForcedPwm,
    output logic [5:0]         buckOneVoltCode,
    output logic               allChannelsOff,   // global shutdown
    output logic               buckFourRetry     // soft start retry
);
    // two-stage synchronisers for all analog and pin inputs
    localparam int SW = 22;
    logic [SW-1:0] syncA_q;
    logic [SW-1:0] syncB_q;
    logic [SW-1:0] syncIn;
    assign syncIn = {opMode, hsOcEndCount, negLimitHit, zeroCrossTrip,
                     buckFourIn, linearOneIn, linearTwoIn, fault_mask,
                     retry_protection_select};
    always_ff @(posedge mclk) begin
        if (srst) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else if (clkEn) begin
            syncA_q <= syncIn;
            syncB_q <= syncA_q;
        end
    end
    // synchronised copies
    logic [2:0] modeS;
    logic       ocEndS;
    logic       negS;
    logic       zcS;
    rsmr_chan_t b4S;
    rsmr_chan_t l1S;
    rsmr_chan_t l2S;
    logic [2:0] maskS;
    logic       retrySelS;
    assign {modeS, ocEndS, negS, zcS, b4S, l1S, l2S, maskS, retrySelS}
        = syncB_q;

    // state registers
    rsmr_setting_t setA_q, setA_d;     // active mode setting
    rsmr_setting_t setL_q, setL_d;     // low-power mode setting
    rsmr_setting_t setH_q, setH_d;     // hibernate mode setting
    logic [3:0]    b4Flag_q, b4Flag_d; // fault, retry, negative, zero
    logic          l1Flt_q, l1Flt_d;
    logic          l2Flt_q, l2Flt_d;
    logic [7:0]    rdata_d;
    rsmr_setting_t applied_q, applied_d;
    logic          intN_d;
    logic [31:0]   waitCnt_q, waitCnt_d;
    logic          off_d;
    logic          retry_d;

    // flag set conditions
    logic b4FltSet, b4RetrySet, l1FltSet, l2FltSet;
    logic pulseSkip;
    assign pulseSkip  = ~applied_q.forcedPwm;
    assign b4RetrySet = ocEndS & ~b4S.powerGood;
    assign b4FltSet   = b4RetrySet | b4Flag_q[2] |
        (b4S.enabledStatus & b4S.softStartDone & ~b4S.powerGood);
    assign l1FltSet   = l1S.enabledStatus & l1S.softStartDone &
                        ~l1S.powerGood;
    assign l2FltSet   = l2S.enabledStatus & l2S.softStartDone &
                        ~l2S.powerGood;

    // next-state logic for registers, flags and read data
    always_comb begin
        setA_d   = setA_q;
        setL_d   = setL_q;
        setH_d   = setH_q;
        b4Flag_d = b4Flag_q;
        l1Flt_d  = l1Flt_q;
        l2Flt_d  = l2Flt_q;
        rdata_d  = regRdata;
        // writes to the mode registers
        if (regWrite) begin
            case (regAddr)
                OFS_BUCK_ONE_ACTIVE:    setA_d = regWdata;
                OFS_BUCK_ONE_LOW_POWER: setL_d = regWdata;
                OFS_BUCK_ONE_HIBERNATE: setH_d = regWdata;
                default: ;
            endcase
        end
        // reads return data, status flags clear on read
        if (regRead) begin
            case (regAddr)
                OFS_BUCK_FOUR_STATUS: begin
                    rdata_d = {b4Flag_q, 1'b0, b4S.softStartDone,
                               b4S.powerGood, b4S.enabledStatus};
                    b4Flag_d = 4'h0;
                end
                OFS_LINEAR_ONE_STATUS: begin
                    rdata_d = {l1Flt_q, 3'h0, l1S.currentLimit,
                               l1S.softStartDone, l1S.powerGood,
                               l1S.enabledStatus};
                    l1Flt_d = 1'b0;
                end
                OFS_LINEAR_TWO_STATUS: begin
                    rdata_d = {l2Flt_q, 3'h0, l2S.currentLimit,
                               l2S.softStartDone, l2S.powerGood,
                               l2S.enabledStatus};
                    l2Flt_d = 1'b0;
                end
                OFS_BUCK_ONE_ACTIVE:    rdata_d = setA_q;
                OFS_BUCK_ONE_LOW_POWER: rdata_d = setL_q;
                OFS_BUCK_ONE_HIBERNATE: rdata_d = setH_q;
                default:                rdata_d = 8'h00;
            endcase
        end
        // hardware sets win over the clear on read
        if (b4FltSet)   b4Flag_d[3] = 1'b1;
        if (b4RetrySet) b4Flag_d[2] = 1'b1;
        if (negS)       b4Flag_d[1] = 1'b1;
        if (zcS & pulseSkip) b4Flag_d[0] = 1'b1;
        if (l1FltSet)   l1Flt_d = 1'b1;
        if (l2FltSet)   l2Flt_d = 1'b1;
    end

    // applied setting, interrupt and short-circuit response
    always_comb begin
        applied_d = applied_q;
        case (modeS)
            RSMR_ACTIVE:    applied_d = setA_q;
            RSMR_LOW_POWER: applied_d = setL_q;
            RSMR_HIBERNATE: applied_d = setH_q;
            default:        applied_d = applied_q;
        endcase
        intN_d = ~((b4Flag_q[3] & ~maskS[2]) | (l1Flt_q & ~maskS[1]) |
                   (l2Flt_q & ~maskS[0]));
        waitCnt_d = waitCnt_q;
        off_d     = allChannelsOff;
        retry_d   = 1'b0;
        if (allChannelsOff) begin
            // count the shutdown wait, then restart the sequence
            if (waitCnt_q >= 32'(RESTART_WAIT - 1)) begin
                off_d     = 1'b0;
                waitCnt_d = '0;
            end else begin
                waitCnt_d = waitCnt_q + 32'd1;
            end
        end else if (b4RetrySet) begin
            if (retrySelS) begin
                retry_d = 1'b1;
            end else begin
                off_d     = 1'b1;
                waitCnt_d = '0;
            end
        end
    end

    // register all state
    always_ff @(posedge mclk) begin
        if (srst) begin
            setA_q    <= RST_ACTIVE_SET;
            setL_q    <= RST_LOWPWR_SET;
            setH_q    <= RST_HIBERN_SET;
            applied_q <= RST_ACTIVE_SET;
            b4Flag_q  <= 4'h0;
            l1Flt_q   <= 1'b0;
            l2Flt_q   <= 1'b0;
            regRdata  <= RST_STATUS;
            interrupt_out_n <= 1'b1;
            waitCnt_q <= '0;
            allChannelsOff <= 1'b0;
            buckOneEnable    <= RST_ACTIVE_SET[7];
            buckOneForcedPwm <= RST_ACTIVE_SET[6];
            buckOneVoltCode  <= RST_ACTIVE_SET[5:0];
            buckFourRetry    <= 1'b0;
        end else if (clkEn) begin
            setA_q    <= setA_d;
            setL_q    <= setL_d;
            setH_q    <= setH_d;
            applied_q <= applied_d;
            b4Flag_q  <= b4Flag_d;
            l1Flt_q   <= l1Flt_d;
            l2Flt_q   <= l2Flt_d;
            regRdata  <= rdata_d;
            interrupt_out_n <= intN_d;
            waitCnt_q <= waitCnt_d;
            allChannelsOff <= off_d;
            // regulator drive follows the applied setting, enable off in shutdown
            buckOneEnable    <= applied_d.enable & ~off_d;
            buckOneForcedPwm <= applied_d.forcedPwm;
            buckOneVoltCode  <= applied_d.outputVoltageCode;
            buckFourRetry    <= retry_d;
        end
    end

    // checks
    chk_read_clears: assert property (@(posedge mclk) disable iff (srst)
        clkEn && regRead && regAddr == OFS_LINEAR_ONE_STATUS && !l1FltSet
        |=> !l1Flt_q) else $error("ldo1 fault not cleared by read");
    chk_buck_fault: assert property (@(posedge mclk) disable iff (srst)
        clkEn && b4RetrySet |=> b4Flag_q[3] && b4Flag_q[2])
        else $error("buck fault or retry not latched");
    chk_retry_latch: assert property (@(posedge mclk) disable iff (srst)
        clkEn && ocEndS && b4S.powerGood && !b4Flag_q[2] && !regRead
        |=> !b4Flag_q[2]) else $error("retry set with power good");
    chk_neg_latch: assert property (@(posedge mclk) disable iff (srst)
        clkEn && negS |=> b4Flag_q[1])
        else $error("negative limit flag missed");
    chk_zero_cross: assert property (@(posedge mclk) disable iff (srst)
        clkEn && zcS && applied_q.forcedPwm && !b4Flag_q[0]
        |=> !b4Flag_q[0]) else $error("zero cross set in forced pwm");
    chk_rsv_zero: assert property (@(posedge mclk) disable iff (srst)
        $past(clkEn && regRead && regAddr == OFS_BUCK_FOUR_STATUS)
        |-> !regRdata[BIT_RESERVED_B]) else $error("reserved bit set");
    chk_ldo_rsv: assert property (@(posedge mclk) disable iff (srst)
        $past(clkEn && regRead && regAddr == OFS_LINEAR_TWO_STATUS)
        |-> regRdata[6:4] == 3'h0) else $error("ldo reserved set");
    chk_mask_int: assert property (@(posedge mclk) disable iff (srst)
        clkEn && maskS == 3'b111 |=> interrupt_out_n)
        else $error("masked fault drove interrupt");
    chk_mode_apply: assert property (@(posedge mclk) disable iff (srst)
        clkEn && modeS == RSMR_HIBERNATE |=> applied_q == $past(setH_q))
        else $error("hibernate setting not applied");
    chk_shutdown: assert property (@(posedge mclk) disable iff (srst)
        clkEn && !allChannelsOff && b4RetrySet && !retrySelS
        |=> allChannelsOff && !buckOneEnable)
        else $error("shutdown missing");
endmodule : rsmr_regs

/* File: test_regulator_status_mode_regs.sv */
// self-checking bench for the regulator status and mode register bank
module test_regulator_status_mode_regs import rsmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RW = 20;      // shortened restart wait
    logic          mclk;
    logic          srst;
    logic          clkEn;        // clock enable of the bank
    logic [2:0]    opMode;
    logic          hsOc;
    logic          negLim;
    logic          zeroX;
    rsmr_chan_t    chan [3];     // buck four, linear one, linear two
    logic [2:0]    faultMask;
    logic          retrySel;
    logic [7:0]    regAddr;
    logic          regWrite;
    logic          regRead;
    logic [7:0]    regWdata;
    logic [7:0]    regRdata;
    logic          intN;
    logic          bOneEn;
    logic          bOnePwm;
    logic [5:0]    bOneCode;
    logic          allOff;
    logic          retryPulse;
    int            n_errors = 0;
    int            tests_run = 0;

    rsmr_host u_rsmr_host (.mclk(mclk), .regRdata(regRdata),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata));
    rsmr_regs #(.RESTART_WAIT(RW)) u_rsmr_regs (.mclk(mclk), .srst(srst),
        .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .opMode(opMode), .hsOcEndCount(hsOc), .negLimitHit(negLim),
        .zeroCrossTrip(zeroX), .buckFourIn(chan[0]),
        .linearOneIn(chan[1]), .linearTwoIn(chan[2]),
        .fault_mask(faultMask), .retry_protection_select(retrySel),
        .interrupt_out_n(intN), .buckOneEnable(bOneEn),
        .buckOneForcedPwm(bOnePwm), .buckOneVoltCode(bOneCode),
        .allChannelsOff(allOff), .buckFourRetry(retryPulse));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // compare one value and count
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // counts, verdict and stop
    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // cut a hang short
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        end_sim();
    end
    // main sequence with the reference model in mreg and lat
    initial begin
        logic [7:0] d;
        logic [7:0] exp;
        logic [7:0] mreg [3];
        logic       lat  [3];
        logic       cond [3];
        int         k;
        void'($urandom(32'h020F35AF));
        mreg = '{8'hF7, 8'hB7, 8'h37};
        lat  = '{1'b0, 1'b0, 1'b0};
        srst = 1'b1;
        clkEn = 1'b1;
        opMode = 3'b001;
        {hsOc, negLim, zeroX, retrySel} = 4'h1;
        chan = '{default: '0};
        faultMask = 3'b111;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        check("buck one out", {bOneEn, bOnePwm, bOneCode}, 8'hF7);
        for (k = 0; k < 3; k++) begin
            u_rsmr_host.rd(8'h10 + 8'(k), d);
            check("mode reset", d, mreg[k]);
            u_rsmr_host.rd(8'h08 + 8'(k), d);
            check("status reset", d, 8'h00);
        end
        // random settings, enable and mode bits stepped through 01,10,11
        for (k = 0; k < 3; k++) begin
            d = 8'($urandom);
            d[7:6] = 2'(k + 1);
            mreg[k] = d;
            u_rsmr_host.wr(8'h10 + 8'(k), d);
        end
        u_rsmr_host.wr(8'h0B, 8'h5A);    // unmapped, ignored
        u_rsmr_host.rd(8'h0B, d);
        check("unmapped", d, 8'h00);
        for (k = 0; k < 3; k++) begin
            u_rsmr_host.rd(8'h10 + 8'(k), d);
            check("mode rw", d, mreg[k]);
            opMode = 3'b001 << k;
            repeat (4) @(negedge mclk);
            check("applied", {bOneEn, bOnePwm, bOneCode}, mreg[k]);
        end
        // zero-cross blocked in forced pwm, taken in pulse skip
        for (k = 0; k < 2; k++) begin
            opMode = k ? 3'b010 : 3'b001;
            repeat (4) @(negedge mclk);
            {zeroX, negLim} = {1'b1, 1'(k)};
            repeat (3) @(negedge mclk);
            {zeroX, negLim} = 2'b00;
            repeat (5) @(negedge mclk);
            u_rsmr_host.rd(8'h08, d);
            check("light load", d, k ? 8'h30 : 8'h00);
        end
        u_rsmr_host.rd(8'h08, d);
        check("cleared", d, 8'h00);
        // frozen clock enable: a pulse during the freeze leaves no flag
        clkEn = 1'b0;
        negLim = 1'b1;
        repeat (3) @(negedge mclk);
        negLim = 1'b0;
        repeat (2) @(negedge mclk);
        clkEn = 1'b1;
        repeat (4) @(negedge mclk);
        u_rsmr_host.rd(8'h08, d);
        check("frozen", d, 8'h00);
        // retry protection selected: retries, no shutdown
        k = 0;
        d = 8'h00;
        for (int j = 0; j < 10; j++) begin
            hsOc = 1'(j < 3);
            @(negedge mclk);
            k += int'(retryPulse === 1'b1);
            d[0] = d[0] | allOff;
        end
        check("retry", {d[0], 7'(k != 0)}, 8'h01);
        u_rsmr_host.rd(8'h08, d);
        check("retry flags", d, 8'hC0);
        u_rsmr_host.rd(8'h08, d);
        check("retry refault", d, 8'h80);
        u_rsmr_host.rd(8'h08, d);
        check("retry clear", d, 8'h00);
        // no retry protection: global shutdown, then restart
        retrySel = 1'b0;
        hsOc = 1'b1;
        repeat (3) @(negedge mclk);
        hsOc = 1'b0;
        for (k = 0; allOff !== 1'b1 && k < 10; k++) @(negedge mclk);
        check("shutdown", {6'h00, allOff, bOneEn}, 8'h02);
        for (k = 0; allOff === 1'b1 && k < 40; k++) @(negedge mclk);
        check("restart", 8'(k >= RW - 3 && k <= RW + 2), 8'h01);
        if (allOff !== 1'b0) end_sim();
        retrySel = 1'b1;
        u_rsmr_host.rd(8'h08, d);
        check("shutdown flags", d, 8'hC0);
        u_rsmr_host.rd(8'h08, d);
        check("shutdown refault", d, 8'h80);
        u_rsmr_host.rd(8'h08, d);
        check("after restart", d, 8'h00);
        // random live status, fault latching and masking
        for (int it = 0; it < 8; it++) begin
            for (int c = 0; c < 3; c++) begin
                chan[c] = rsmr_chan_t'(4'($urandom));
                cond[c] = chan[c].enabledStatus & chan[c].softStartDone
                          & ~chan[c].powerGood;
                lat[c] = lat[c] | cond[c];
            end
            faultMask = 3'($urandom);
            repeat (6) @(negedge mclk);
            exp = {7'h00, ~((lat[0] & ~faultMask[2]) |
                  (lat[1] & ~faultMask[1]) | (lat[2] & ~faultMask[0]))};
            check("interrupt", {7'h00, intN}, exp);
            for (int c = 0; c < 3; c++) begin
                u_rsmr_host.rd(8'h08 + 8'(c), d);
                exp = {lat[c], 3'b000, (c > 0) & chan[c].currentLimit,
                       chan[c].softStartDone, chan[c].powerGood,
                       chan[c].enabledStatus};
                check("status", d, exp);
                lat[c] = cond[c];
            end
        end
        end_sim();
    end
endmodule : test_regulator_status_mode_regs
